// ==== hw/tkc_core.v ====
// Tiny 8-bit controller core: register bank, ALU, flags, return stack,
// port strobes and one maskable interrupt, two clocks per instruction.
// Assumes an asynchronous-read program memory and port logic on clk.
//
// What this block does
// - Eight interchangeable 8-bit general registers, none special.
// - ALU reads register X, writes back to X; second operand register or constant.
// - Add and subtract variants that include the carry flag.
// - ALU sets zero and carry; only these are tested by conditions.
// - 256 in and out ports, 8-bit port address with read or write pulse.
// - Port address from instruction constant or any register.
// - Input loads port data into register and pulses read strobe.
// - Output drives register onto output port and pulses write strobe.
// - One interrupt input, masked after reset, program enables and disables it.
// - Enabled interrupt calls address ff and pushes the return address.
// - Interrupt entry saves zero and carry and disables interrupts.
// - Interrupt return restores saved flags and sets the enable state.
// - Every instruction, branch and interrupt entry takes exactly two clocks.
// - Program space of 256 words; 8-bit addresses carried in instructions.
// - Program counter increments and wraps from ff to 00.
// - Jump loads target, unconditionally or on flag test, flags untouched.
// - Call pushes current counter then loads target, flags untouched.
// - Four-deep cyclic return stack; overflow overwrites oldest, no control.
// - Return pops top and loads it plus one; flags untouched.
// - Shifts and rotates both ways inject 0, 1, end bit, carry or other end.
// - Interrupt return reloads the saved address without increment.
// - Load copies constant or register, flags unchanged.
// - Exclusive-or sets zero from result and clears carry.
// - Enable and disable instructions set and clear the interrupt enable.

`timescale 1ns/1ps
`include "tkc_regs.vh"

module tkc_core #(
  parameter STACK_DEPTH_LOG2 = 2
) (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst_n,
  // Program memory.
  output reg  [7:0]  instr_addr,
  input  wire [15:0] instr,
  // Port bus.
  output reg  [7:0]  port_id,
  output reg  [7:0]  out_port,
  output reg         write_strobe,
  output reg         read_strobe,
  input  wire [7:0]  in_port,
  // Interrupt.
  input  wire        interrupt,
  output reg         interrupt_ack
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  reg [7:0]  general_regs [0:7];
  reg [7:0]  stack_q  [0:(1<<STACK_DEPTH_LOG2)-1];
  reg [STACK_DEPTH_LOG2-1:0] sp_q;
  reg [7:0]  pc_q;
  reg [15:0] ir_q;
  reg        phase_q;
  reg        zero_q;
  reg        carry_q;
  reg        zero_save_q;
  reg        carry_save_q;
  reg        int_en_q;
  reg        int_take_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the held instruction.

  wire [3:0] op      = ir_q[`TKC_OP_HI:`TKC_OP_LO];
  wire [2:0] rx      = ir_q[`TKC_X_HI:`TKC_X_LO];
  wire [2:0] ry      = ir_q[`TKC_Y_HI:`TKC_Y_LO];
  wire [7:0] kk      = ir_q[`TKC_K_HI:`TKC_K_LO];
  wire [7:0] a_val   = general_regs[rx];
  wire [7:0] b_val   = ir_q[`TKC_SEL_REG] ? general_regs[ry] : kk;
  wire [STACK_DEPTH_LOG2-1:0] sp_inc = sp_q + 1'b1;
  wire [7:0] stack_top = stack_q[sp_q];

  // Condition test on the two flags only.
  function cond_ok;
    input [2:0] cc;
    input       z;
    input       c;
    begin
      case (cc)
        `TKC_CC_Z:  cond_ok = z;
        `TKC_CC_NZ: cond_ok = ~z;
        `TKC_CC_C:  cond_ok = c;
        `TKC_CC_NC: cond_ok = ~c;
        default:    cond_ok = 1'b1;
      endcase
    end
  endfunction

  wire take = cond_ok(rx, zero_q, carry_q);

  ////////////////////////////////////////////////////////////////////////////
  // ALU and shifter.

  reg [7:0] alu_res;
  reg       alu_c;
  reg       alu_wr;
  reg       alu_flags;
  reg [8:0] sum;
  reg       inj;

  always @* begin
    sum       = 9'h000;
    inj       = 1'b0;
    alu_res   = a_val;
    alu_c     = carry_q;
    alu_wr    = 1'b0;
    alu_flags = 1'b0;
    case (op)
      `TKC_OP_LOAD: begin
        alu_res = b_val;
        alu_wr  = 1'b1;
      end
      `TKC_OP_AND: begin
        alu_res   = a_val & b_val;
        alu_c     = 1'b0;
        alu_wr    = 1'b1;
        alu_flags = 1'b1;
      end
      `TKC_OP_OR: begin
        alu_res   = a_val | b_val;
        alu_c     = 1'b0;
        alu_wr    = 1'b1;
        alu_flags = 1'b1;
      end
      `TKC_OP_XOR: begin
        alu_res   = a_val ^ b_val;
        alu_c     = 1'b0;
        alu_wr    = 1'b1;
        alu_flags = 1'b1;
      end
      `TKC_OP_ADD, `TKC_OP_ADDCY: begin
        sum       = {1'b0, a_val} + {1'b0, b_val}
                    + {8'h00, (op == `TKC_OP_ADDCY) & carry_q};
        alu_res   = sum[7:0];
        alu_c     = sum[8];
        alu_wr    = 1'b1;
        alu_flags = 1'b1;
      end
      `TKC_OP_SUB, `TKC_OP_SUBCY: begin
        // Carry holds the borrow out of the subtraction.
        sum       = {1'b0, a_val} - {1'b0, b_val}
                    - {8'h00, (op == `TKC_OP_SUBCY) & carry_q};
        alu_res   = sum[7:0];
        alu_c     = sum[8];
        alu_wr    = 1'b1;
        alu_flags = 1'b1;
      end
      `TKC_OP_SHIFT: begin
        alu_wr    = 1'b1;
        alu_flags = 1'b1;
        if (ir_q[`TKC_SH_DIR]) begin
          case (ir_q[`TKC_SH_INJ_HI:`TKC_SH_INJ_LO])
            `TKC_INJ_ONE:   inj = 1'b1;
            `TKC_INJ_END:   inj = a_val[0];
            `TKC_INJ_CARRY: inj = carry_q;
            `TKC_INJ_ROT:   inj = a_val[7];
            default:        inj = 1'b0;
          endcase
          alu_res = {a_val[6:0], inj};
          alu_c   = a_val[7];
        end else begin
          case (ir_q[`TKC_SH_INJ_HI:`TKC_SH_INJ_LO])
            `TKC_INJ_ONE:   inj = 1'b1;
            `TKC_INJ_END:   inj = a_val[7];
            `TKC_INJ_CARRY: inj = carry_q;
            `TKC_INJ_ROT:   inj = a_val[0];
            default:        inj = 1'b0;
          endcase
          alu_res = {inj, a_val[7:1]};
          alu_c   = a_val[0];
        end
      end
      `TKC_OP_INPUT: begin
        alu_res = in_port;
        alu_wr  = 1'b1;
      end
      default: begin
        alu_res = a_val;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bank and stack storage; left without reset on purpose.

  always @(posedge clk) begin
    if (phase_q == `TKC_PH_EXEC) begin
      if (int_take_q) begin
        stack_q[sp_inc] <= pc_q;
      end else begin
        if (alu_wr) begin
          general_regs[rx] <= alu_res;
        end
        if (op == `TKC_OP_CALL && take) begin
          stack_q[sp_inc] <= pc_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: fetch on phase 0, execute on phase 1.

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q       <= `TKC_PH_FETCH;
      pc_q          <= `TKC_PC_RESET;
      instr_addr    <= `TKC_PC_RESET;
      ir_q          <= 16'h0000;
      sp_q          <= {STACK_DEPTH_LOG2{1'b0}};
      zero_q        <= 1'b0;
      carry_q       <= 1'b0;
      zero_save_q   <= 1'b0;
      carry_save_q  <= 1'b0;
      int_en_q      <= 1'b0;
      int_take_q    <= 1'b0;
      port_id       <= 8'h00;
      out_port      <= 8'h00;
      write_strobe  <= 1'b0;
      read_strobe   <= 1'b0;
      interrupt_ack <= 1'b0;
    end else begin
      phase_q       <= ~phase_q;
      write_strobe  <= 1'b0;
      read_strobe   <= 1'b0;
      interrupt_ack <= 1'b0;
      if (phase_q == `TKC_PH_FETCH) begin
        ir_q <= instr;
        // Interrupt is looked at only here, so entry still costs two clocks.
        if (int_en_q && interrupt) begin
          int_take_q    <= 1'b1;
          interrupt_ack <= 1'b1;
        end else begin
          int_take_q <= 1'b0;
          port_id    <= instr[`TKC_SEL_REG] ? general_regs[instr[`TKC_Y_HI:`TKC_Y_LO]]
                                            : instr[`TKC_K_HI:`TKC_K_LO];
          out_port   <= general_regs[instr[`TKC_X_HI:`TKC_X_LO]];
          write_strobe <= (instr[`TKC_OP_HI:`TKC_OP_LO] == `TKC_OP_OUTPUT);
          read_strobe  <= (instr[`TKC_OP_HI:`TKC_OP_LO] == `TKC_OP_INPUT);
        end
      end else begin
        int_take_q <= 1'b0;
        if (int_take_q) begin
          // Unexecuted instruction's address is pushed; the service returns to it.
          sp_q         <= sp_inc;
          pc_q         <= `TKC_INT_VECTOR;
          instr_addr   <= `TKC_INT_VECTOR;
          zero_save_q  <= zero_q;
          carry_save_q <= carry_q;
          int_en_q     <= 1'b0;
        end else begin
          if (alu_flags) begin
            zero_q  <= (alu_res == 8'h00);
            carry_q <= alu_c;
          end
          case (op)
            `TKC_OP_JUMP: begin
              pc_q       <= take ? kk : pc_q + 8'h01;
              instr_addr <= take ? kk : pc_q + 8'h01;
            end
            `TKC_OP_CALL: begin
              if (take) begin
                sp_q <= sp_inc;
              end
              pc_q       <= take ? kk : pc_q + 8'h01;
              instr_addr <= take ? kk : pc_q + 8'h01;
            end
            `TKC_OP_RETURN: begin
              if (take) begin
                sp_q <= sp_q - 1'b1;
              end
              pc_q       <= take ? stack_top + 8'h01 : pc_q + 8'h01;
              instr_addr <= take ? stack_top + 8'h01 : pc_q + 8'h01;
            end
            `TKC_OP_RETI: begin
              sp_q       <= sp_q - 1'b1;
              pc_q       <= stack_top;
              instr_addr <= stack_top;
              zero_q     <= zero_save_q;
              carry_q    <= carry_save_q;
              int_en_q   <= ir_q[`TKC_IE_BIT];
            end
            `TKC_OP_INTCTL: begin
              int_en_q   <= ir_q[`TKC_IE_BIT];
              pc_q       <= pc_q + 8'h01;
              instr_addr <= pc_q + 8'h01;
            end
            default: begin
              pc_q       <= pc_q + 8'h01;
              instr_addr <= pc_q + 8'h01;
            end
          endcase
        end
      end
    end
  end

endmodule

// ==== hw/tkc_regs.vh ====
// Constants for the tiny 8-bit controller core: instruction fields, opcodes,
// shift codes, condition codes, vectors and reset values.
// Assumes a 16-bit instruction word supplied by an external program memory.
`ifndef TKC_REGS_VH
`define TKC_REGS_VH

// Instruction word fields.
`define TKC_OP_HI      15
`define TKC_OP_LO      12
`define TKC_SEL_REG    11
`define TKC_X_HI       10
`define TKC_X_LO       8
`define TKC_Y_HI       7
`define TKC_Y_LO       5
`define TKC_K_HI       7
`define TKC_K_LO       0
`define TKC_SH_DIR     3
`define TKC_SH_INJ_HI  2
`define TKC_SH_INJ_LO  0
`define TKC_IE_BIT     0

// Opcodes.
`define TKC_OP_LOAD    4'h0
`define TKC_OP_AND     4'h1
`define TKC_OP_OR      4'h2
`define TKC_OP_XOR     4'h3
`define TKC_OP_ADD     4'h4
`define TKC_OP_ADDCY   4'h5
`define TKC_OP_SUB     4'h6
`define TKC_OP_SUBCY   4'h7
`define TKC_OP_SHIFT   4'h8
`define TKC_OP_INPUT   4'h9
`define TKC_OP_OUTPUT  4'ha
`define TKC_OP_JUMP    4'hb
`define TKC_OP_CALL    4'hc
`define TKC_OP_RETURN  4'hd
`define TKC_OP_RETI    4'he
`define TKC_OP_INTCTL  4'hf

// Shift inject codes (bit 3 of the word selects left when set).
`define TKC_INJ_ZERO   3'h0
`define TKC_INJ_ONE    3'h1
`define TKC_INJ_END    3'h2
`define TKC_INJ_CARRY  3'h3
`define TKC_INJ_ROT    3'h4

// Condition codes in the X field of flow instructions.
`define TKC_CC_ALWAYS  3'h0
`define TKC_CC_Z       3'h4
`define TKC_CC_NZ      3'h5
`define TKC_CC_C       3'h6
`define TKC_CC_NC      3'h7

// Vectors, phases and reset values.
`define TKC_INT_VECTOR 8'hff
`define TKC_PC_RESET   8'h00
`define TKC_PH_FETCH   1'b0
`define TKC_PH_EXEC    1'b1

`endif

// ==== testbench/tkc_core_properties.sv ====
// Concurrent checks on the controller core's ports.
// Assumes a bind to tkc_core, one clock, asynchronous active-low reset.
`timescale 1ns/1ps
module tkc_core_properties (
  // Clock and reset.
  input wire        clk,
  input wire        rst_n,
  // Program and port bus.
  input wire [7:0]  instr_addr,
  input wire [7:0]  port_id,
  input wire [7:0]  out_port,
  input wire        write_strobe,
  input wire        read_strobe,
  // Interrupt.
  input wire        interrupt,
  input wire        interrupt_ack
);
////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_write_pulse: assert property (write_strobe |=> !write_strobe)
    else $error("write strobe too long");
  chk_read_pulse: assert property (read_strobe |=> !read_strobe)
    else $error("read strobe too long");
  chk_addr_hold: assert property ($changed(instr_addr) |=> $stable(instr_addr))
    else $error("program address changed on consecutive edges");
  chk_int_vector: assert property (interrupt_ack |=> instr_addr == 8'hff)
    else $error("interrupt did not vector to ff");
  chk_ack_gap: assert property (interrupt_ack |=> !interrupt_ack [*3])
    else $error("interrupt taken again too soon");
  chk_ack_cause: assert property (interrupt_ack |-> $past(interrupt))
    else $error("ack without sampled interrupt");
  chk_reset_start: assert property ($rose(rst_n) |->
    instr_addr == 8'h00 && !read_strobe && !write_strobe)
    else $error("bad state after reset");
  chk_reset_masked: assert property ($rose(rst_n) |-> !interrupt_ack [*3])
    else $error("interrupt taken while masked");
  chk_port_hold: assert property ((write_strobe || read_strobe) |=>
    $stable(port_id) && $stable(out_port))
    else $error("port address or data moved after strobe");
endmodule

// ==== testbench/tkc_port_model.sv ====
// User port decode and interrupt source beside the controller core.
// Assumes the core's clock; int_req is a one-cycle command from the bench.
`timescale 1ns/1ps
module tkc_port_model (
  // Clock and reset.
  input wire        clk,
  input wire        rst_n,
  // Port bus.
  input wire [7:0]  port_id,
  input wire [7:0]  out_port,
  input wire        write_strobe,
  input wire        read_strobe,
  output logic [7:0] in_port,
  // Interrupt.
  input wire        int_req,
  input wire        interrupt_ack,
  output logic      interrupt
);
////////////////////////////////////////////////////////////////
  logic [7:0] mem [0:255];
  logic [7:0] hit [0:255];
  int         ack_cnt;
  int         rd_cnt;

  // Input data is decoded from the address alone; the read strobe is only counted.
  assign in_port = port_id ^ 8'ha5;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt <= 1'b0;
      ack_cnt <= 0;
      rd_cnt <= 0;
      for (int i = 0; i < 256; i++) hit[i] <= 8'h00;
    end else begin
      if (interrupt_ack) interrupt <= 1'b0;
      else if (int_req) interrupt <= 1'b1;
      if (interrupt_ack) ack_cnt <= ack_cnt + 1;
      if (read_strobe) rd_cnt <= rd_cnt + 1;
      // Output data is captured only when qualified by the write strobe.
      if (write_strobe) begin
        mem[port_id] <= out_port;
        hit[port_id] <= hit[port_id] + 8'h01;
      end
    end
  end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the controller core with a program ROM array.
// Assumes the core, its port model and its checker are compiled alongside.
`timescale 1ns/1ps
`include "tkc_regs.vh"
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        int_req = 1'b0;
  logic [15:0] rom [0:255];
  wire  [7:0]  instr_addr, port_id, out_port, in_port;
  wire         write_strobe, read_strobe, interrupt, interrupt_ack;
  int          error_cnt = 0;
  int          cmp_count = 0;

  always #12.5 clk = ~clk;

  tkc_core i_dut (.clk(clk), .rst_n(rst_n), .instr_addr(instr_addr), .instr(rom[instr_addr]),
    .port_id(port_id), .out_port(out_port), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .in_port(in_port), .interrupt(interrupt),
    .interrupt_ack(interrupt_ack));
  tkc_port_model i_part (.clk(clk), .rst_n(rst_n), .port_id(port_id), .out_port(out_port),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .in_port(in_port),
    .int_req(int_req), .interrupt_ack(interrupt_ack), .interrupt(interrupt));
////////////////////////////////////////////////////////////////
  function automatic logic [15:0] ik(input logic [3:0] op, input logic [2:0] x,
                                     input logic [7:0] k);
    return {op, 1'b0, x, k};
  endfunction
  function automatic logic [15:0] ir(input logic [3:0] op, input logic [2:0] x,
                                     input logic [2:0] y);
    return {op, 1'b1, x, y, 5'h00};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Every unused word jumps to itself so a program never wraps into a rerun.
  task automatic clr;
    for (int i = 0; i < 256; i++) rom[i] = ik(`TKC_OP_JUMP, `TKC_CC_ALWAYS, i[7:0]);
  endtask

  task automatic boot(input int n);
    // Reset drops in the step of the program load, before the old program sees an edge.
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (n) @(negedge clk);
  endtask
////////////////////////////////////////////////////////////////
  task automatic t_alu;
    clr;
    rom[0] = ik(`TKC_OP_LOAD, 0, 8'hf0);
    rom[1] = ik(`TKC_OP_ADD, 0, 8'h20);
    rom[2] = ik(`TKC_OP_LOAD, 1, 8'h00);
    rom[3] = ik(`TKC_OP_ADDCY, 1, 8'h00);
    rom[4] = ik(`TKC_OP_LOAD, 2, 8'h05);
    rom[5] = ik(`TKC_OP_SUB, 2, 8'h06);
    rom[6] = ik(`TKC_OP_LOAD, 3, 8'h00);
    rom[7] = ir(`TKC_OP_SUBCY, 2, 3);
    rom[8] = ik(`TKC_OP_LOAD, 4, 8'h33);
    rom[9] = ir(`TKC_OP_INPUT, 5, 4);
    rom[10] = ir(`TKC_OP_OUTPUT, 5, 4);
    rom[11] = ik(`TKC_OP_OUTPUT, 0, 8'h01);
    rom[12] = ik(`TKC_OP_OUTPUT, 1, 8'h02);
    rom[13] = ik(`TKC_OP_OUTPUT, 2, 8'h03);
    rom[14] = ik(`TKC_OP_XOR, 2, 8'hfe);
    rom[15] = ik(`TKC_OP_JUMP, `TKC_CC_Z, 8'h11);
    rom[16] = ik(`TKC_OP_OUTPUT, 2, 8'h04);
    rom[17] = ik(`TKC_OP_CALL, `TKC_CC_NC, 8'h40);
    rom[18] = ik(`TKC_OP_OUTPUT, 0, 8'h05);
    rom[19] = ik(`TKC_OP_AND, 0, 8'h0f);
    rom[20] = ik(`TKC_OP_JUMP, `TKC_CC_NZ, 8'h16);
    rom[21] = ik(`TKC_OP_OUTPUT, 0, 8'h06);
    rom[22] = ik(`TKC_OP_OUTPUT, 0, 8'h07);
    rom[23] = ik(`TKC_OP_INPUT, 6, 8'h5c);
    rom[24] = ik(`TKC_OP_OUTPUT, 6, 8'h09);
    rom[25] = ik(`TKC_OP_ADD, 0, 8'hff);
    rom[26] = ik(`TKC_OP_XOR, 0, 8'h00);
    rom[27] = ik(`TKC_OP_JUMP, `TKC_CC_C, 8'h1d);
    rom[28] = ik(`TKC_OP_OUTPUT, 0, 8'h08);
    rom[64] = ik(`TKC_OP_ADD, 0, 8'h01);
    rom[65] = ik(`TKC_OP_RETURN, `TKC_CC_C, 8'h00);
    rom[66] = ik(`TKC_OP_RETURN, `TKC_CC_ALWAYS, 8'h00);
    boot(80);
    check(i_part.mem[8'h01], 8'hf0 + 8'h20);
    check(i_part.mem[8'h02], 8'h01);
    check(i_part.mem[8'h03], 8'h05 - 8'h06 - 8'h01);
    check(i_part.mem[8'h33], 8'h33 ^ 8'ha5);
    check(i_part.hit[8'h04], 8'h00);
    check(i_part.mem[8'h05], 8'hf0 + 8'h20 + 8'h01);
    check(i_part.hit[8'h05], 8'h01);
    check(i_part.hit[8'h06], 8'h00);
    check(i_part.mem[8'h07], 8'h01);
    check(i_part.mem[8'h09], 8'h5c ^ 8'ha5);
    check(i_part.hit[8'h08], 8'h01);
    check(i_part.rd_cnt[7:0], 8'h02);
  endtask

  task automatic t_shift;
    logic [7:0] v;
    logic       inj;
    logic       d;
    logic [2:0] c;
    v = 8'h96;
    clr;
    for (int i = 0; i < 10; i++) begin
      d = (i >= 5);
      c = 3'(i % 5);
      rom[i*5] = ik(`TKC_OP_LOAD, 7, 8'hff);
      rom[i*5+1] = ik(`TKC_OP_ADD, 7, 8'h01);
      rom[i*5+2] = ik(`TKC_OP_LOAD, 0, v);
      rom[i*5+3] = {`TKC_OP_SHIFT, 8'h00, d, c};
      rom[i*5+4] = ik(`TKC_OP_OUTPUT, 0, i[7:0]);
    end
    boot(110);
    for (int i = 0; i < 10; i++) begin
      d = (i >= 5);
      c = 3'(i % 5);
      inj = (c == 1) || (c == 3) || (c == 2 && (d ? v[0] : v[7])) ||
            (c == 4 && (d ? v[7] : v[0]));
      check(i_part.mem[i], d ? {v[6:0], inj} : {inj, v[7:1]});
    end
  endtask

  task automatic t_stack;
    clr;
    rom[0] = ik(`TKC_OP_LOAD, 0, 8'h5a);
    rom[1] = ik(`TKC_OP_CALL, `TKC_CC_ALWAYS, 8'h10);
    rom[2] = ik(`TKC_OP_OUTPUT, 0, 8'h02);
    for (int i = 1; i < 6; i++) begin
      rom[i*16] = ik(`TKC_OP_CALL, `TKC_CC_ALWAYS, 8'((i + 1) * 16));
      rom[i*16+1] = ik(`TKC_OP_OUTPUT, 0, 8'(i * 16 + 1));
      rom[i*16+2] = ik(`TKC_OP_RETURN, `TKC_CC_ALWAYS, 8'h00);
    end
    rom[96] = ik(`TKC_OP_RETURN, `TKC_CC_ALWAYS, 8'h00);
    boot(70);
    check(i_part.hit[8'h02], 8'h00);
    check(i_part.hit[8'h11], 8'h00);
    check(i_part.mem[8'h21], 8'h5a);
    check(i_part.hit[8'h51], 8'h04);
  endtask

  task automatic t_int;
    clr;
    rom[0] = ik(`TKC_OP_LOAD, 1, 8'h00);
    rom[1] = ik(`TKC_OP_OR, 1, 8'h00);
    rom[2] = ik(`TKC_OP_INTCTL, 0, 8'h01);
    rom[3] = ik(`TKC_OP_JUMP, `TKC_CC_Z, 8'h03);
    rom[4] = ik(`TKC_OP_OUTPUT, 1, 8'h61);
    rom[255] = ik(`TKC_OP_JUMP, `TKC_CC_ALWAYS, 8'h80);
    rom[128] = ik(`TKC_OP_LOAD, 2, 8'h01);
    rom[129] = ik(`TKC_OP_ADD, 2, 8'h01);
    rom[130] = ik(`TKC_OP_OUTPUT, 2, 8'h60);
    rom[131] = ik(`TKC_OP_RETI, 0, 8'h01);
    boot(20);
    int_req = 1'b1;
    @(negedge clk) int_req = 1'b0;
    repeat (40) @(negedge clk);
    check(i_part.ack_cnt[7:0], 8'h01);
    check(i_part.mem[8'h60], 8'h02);
    check(i_part.hit[8'h61], 8'h00);
    int_req = 1'b1;
    @(negedge clk) int_req = 1'b0;
    repeat (40) @(negedge clk);
    check(i_part.ack_cnt[7:0], 8'h02);
    check(i_part.hit[8'h60], 8'h02);
    rom[3] = ik(`TKC_OP_INTCTL, 0, 8'h00);
    rom[4] = ik(`TKC_OP_JUMP, `TKC_CC_ALWAYS, 8'h04);
    repeat (10) @(negedge clk);
    int_req = 1'b1;
    @(negedge clk) int_req = 1'b0;
    repeat (40) @(negedge clk);
    check(i_part.ack_cnt[7:0], 8'h02);
    check({7'h00, i_part.interrupt}, 8'h01);
    check(i_part.hit[8'h61], 8'h00);
  endtask

  initial begin
    clr;
    t_alu;
    t_shift;
    t_stack;
    t_int;
    summarize;
  end

  initial begin
    #50us;
    error_cnt++;
    summarize;
  end
endmodule

bind tkc_core tkc_core_properties i_chk (.clk(clk), .rst_n(rst_n), .instr_addr(instr_addr),
  .port_id(port_id), .out_port(out_port), .write_strobe(write_strobe),
  .read_strobe(read_strobe), .interrupt(interrupt), .interrupt_ack(interrupt_ack));
